//--- logic/qdec_pkg.sv
// Package: shared constants and types for the quadrature decoder
`default_nettype none
package qdec_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_POS    = 8'h04;
  localparam logic [7:0] OFF_VEL    = 8'h08;
  localparam logic [7:0] OFF_REV    = 8'h0C;
  localparam logic [7:0] OFF_VPER   = 8'h10;
  localparam logic [7:0] OFF_VTHR   = 8'h14;
  localparam logic [7:0] OFF_CMP0   = 8'h18;
  localparam logic [7:0] OFF_CMP1   = 8'h1C;
  localparam logic [7:0] OFF_CMP2   = 8'h20;
  localparam logic [7:0] OFF_ICMP   = 8'h24;
  localparam logic [7:0] OFF_FILT   = 8'h28;
  localparam logic [7:0] OFF_STAT   = 8'h2C;
  localparam logic [7:0] OFF_IEN    = 8'h30;
  // Control field positions
  localparam int CTRL_X4     = 0;
  localparam int CTRL_CLKDIR = 1;
  localparam int CTRL_IDXRST = 2;
  localparam int CTRL_W      = 3;
  // Status and enable bit positions
  localparam int ST_CMP0   = 0;
  localparam int ST_CMP1   = 1;
  localparam int ST_CMP2   = 2;
  localparam int ST_ICMP   = 3;
  localparam int ST_VLOW   = 4;
  localparam int ST_COMB   = 5;
  localparam int ST_INDEX  = 6;
  localparam int ST_VCAP   = 7;
  localparam int ST_PHERR  = 8;
  localparam int ST_W      = 9;
  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h1;
  localparam logic [31:0]       VPER_RST = 32'h000F_4240;
  localparam logic [31:0]       VTHR_RST = 32'h0000_0000;
  localparam logic [31:0]       CMP_RST  = 32'hFFFF_FFFF;
  localparam logic [15:0]       FILT_RST = 16'h0003;
  localparam logic [31:0]       ZERO32   = 32'h0000_0000;
  localparam logic [31:0]       ONE32    = 32'h0000_0001;
  localparam int                FILT_W   = 16;
  // Encoder input bundle
  typedef struct packed {
    logic idx;
    logic b;
    logic a;
  } qdec_enc_t;
endpackage
`default_nettype wire

//--- logic/qdec_filter.sv
// Module: input synchroniser and stability filter for one encoder line
`timescale 1ns/1ps
`default_nettype none
module qdec_filter #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Raw line and programmed delay
  input  wire logic         din,
  input  wire logic [W-1:0] delay,
  // Accepted level
  output logic              dout
);
  logic         s1_r;
  logic         s2_r;
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         out_nxt;

  always_comb
  begin
    cnt_nxt = '0;
    out_nxt = dout;
    if (s2_r != dout)
    begin
      // Accept only after the level stood for the full delay
      if (cnt_r >= delay)
        out_nxt = s2_r;
      else
        cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      cnt_r <= '0;
      dout  <= 1'b0;
    end
    else
    begin
      s1_r  <= din;
      s2_r  <= s1_r;
      cnt_r <= cnt_nxt;
      dout  <= out_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_filt_accept: assert property ( // [R12]
    dout != $past(dout) |-> $past(cnt_r) >= $past(delay))
    else $error("filter changed before delay expired");
endmodule
`default_nettype wire

//--- logic/qdec_top.sv
// Module: quadrature decoder with APB registers and interrupt
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: Direction comes from the phase relation of A and B, and their edges move the position.
// R2: Position counts up for one direction and down for the other.
// R3: A control bit picks 2x counting (A edges) or 4x counting (all A and B edges).
// R4: An index rising edge can clear the position counter when enabled.
// R5: Position and velocity are held in 32-bit registers.
// R6: A reload timer sets the period; the steps counted in it become the velocity.
// R7: A captured velocity below the threshold raises its interrupt flag.
// R8: Three position compare values each raise their own flag on equality.
// R9: A revolution counter moves by one on each index pulse.
// R10: Revolution count equal to the index compare value raises a flag.
// R11: Index match together with compare 0 match raises a combined flag.
// R12: Each input line is filtered by a programmable stability delay.
// R13: Clock-and-direction mode counts one step per A rise, direction from B.
// R14: Each source sets a sticky flag; only enabled flags drive the interrupt.
// R15: Inputs are synchronised before filtering; in quadrature mode a change of both phases is ignored.
// R16: Reset clears counters, flags and interrupt enables.
module qdec_top (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Encoder lines
  input  wire logic        ENC_A,
  input  wire logic        ENC_B,
  input  wire logic        ENC_IDX,
  // Status outputs
  output logic             IRQ,
  output logic             DIR
);
  qdec_pkg::qdec_enc_t raw;
  wire qdec_pkg::qdec_enc_t flt;
  qdec_pkg::qdec_enc_t prev_r;

  logic [qdec_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [31:0] pos_r, pos_nxt;
  logic [31:0] rev_r, rev_nxt;
  logic [31:0] vel_r, vel_nxt;
  logic [31:0] acc_r, acc_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [31:0] vper_r, vper_nxt;
  logic [31:0] vthr_r, vthr_nxt;
  logic [31:0] cmp_r [3];
  logic [31:0] cmp_nxt [3];
  logic [31:0] icmp_r, icmp_nxt;
  logic [qdec_pkg::FILT_W-1:0] filt_r, filt_nxt;
  logic [qdec_pkg::ST_W-1:0]   stat_r, stat_nxt, ev;
  logic [qdec_pkg::ST_W-1:0]   ien_r, ien_nxt;
  logic        dir_nxt;
  logic        irq_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;

  logic chg_a, chg_b, both, step_up, step_dn, step, idx_rise, clr_pos;
  logic wr_en, tmr_zero, mapped;
  logic [qdec_pkg::ST_W-1:0] w1c;

  assign raw = '{idx: ENC_IDX, b: ENC_B, a: ENC_A};

  // Three identical filtered lines, each synchronised first [R15]
  qdec_filter #(.W(qdec_pkg::FILT_W)) u_fa (
    .clk   (CORE_CLK),
    .rst   (RESET),
    .din   (raw.a),
    .delay (filt_r),
    .dout  (flt.a)
  );
  qdec_filter #(.W(qdec_pkg::FILT_W)) u_fb (
    .clk   (CORE_CLK),
    .rst   (RESET),
    .din   (raw.b),
    .delay (filt_r),
    .dout  (flt.b)
  );
  qdec_filter #(.W(qdec_pkg::FILT_W)) u_fi (
    .clk   (CORE_CLK),
    .rst   (RESET),
    .din   (raw.idx),
    .delay (filt_r),
    .dout  (flt.idx)
  );

  // Step decode
  always_comb
  begin
    chg_a    = flt.a ^ prev_r.a;
    chg_b    = flt.b ^ prev_r.b;
    both     = chg_a & chg_b;
    step_up  = 1'b0;
    step_dn  = 1'b0;
    idx_rise = flt.idx & ~prev_r.idx;
    if (ctrl_r[qdec_pkg::CTRL_CLKDIR])
    begin
      // B low means count up [R13]
      step_up = flt.a & ~prev_r.a & ~flt.b;
      step_dn = flt.a & ~prev_r.a & flt.b;
    end
    else if (!both) // [R15]
    begin
      // Leading phase sets direction [R1]
      if (chg_a)
      begin
        step_up = flt.a ^ flt.b;
        step_dn = ~(flt.a ^ flt.b);
      end
      else if (chg_b && ctrl_r[qdec_pkg::CTRL_X4]) // [R3]
      begin
        step_up = ~(flt.a ^ flt.b);
        step_dn = flt.a ^ flt.b;
      end
    end
    step    = step_up | step_dn;
    clr_pos = idx_rise & ctrl_r[qdec_pkg::CTRL_IDXRST];
  end

  // Counters, timer and events
  always_comb
  begin
    dir_nxt = DIR;
    if (step)
      dir_nxt = step_up;
    pos_nxt = pos_r;
    if (clr_pos)
      pos_nxt = qdec_pkg::ZERO32; // [R4]
    else if (step_up)
      pos_nxt = pos_r + qdec_pkg::ONE32; // [R2]
    else if (step_dn)
      pos_nxt = pos_r - qdec_pkg::ONE32; // [R2]
    rev_nxt = rev_r;
    if (idx_rise)
      rev_nxt = dir_nxt ? rev_r + qdec_pkg::ONE32
                        : rev_r - qdec_pkg::ONE32; // [R9]
    tmr_zero = (tmr_r == qdec_pkg::ZERO32);
    // New period applies at once, except in a reload cycle, where the old one runs once more
    if (tmr_zero)
      tmr_nxt = vper_r; // [R6]
    else if (wr_en && (PADDR == qdec_pkg::OFF_VPER))
      tmr_nxt = PWDATA;
    else
      tmr_nxt = tmr_r - qdec_pkg::ONE32;
    vel_nxt  = tmr_zero ? acc_r : vel_r; // [R5] [R6]
    // Step in the capture cycle opens the next period
    acc_nxt  = (tmr_zero ? qdec_pkg::ZERO32 : acc_r)
             + {31'h0000_0000, step};
    ev = '0;
    for (int i = 0; i < 3; i++)
      ev[qdec_pkg::ST_CMP0 + i] = (pos_nxt != pos_r) &&
                                  (pos_nxt == cmp_r[i]); // [R8]
    ev[qdec_pkg::ST_ICMP]  = idx_rise && (rev_nxt == icmp_r); // [R10]
    ev[qdec_pkg::ST_VLOW]  = tmr_zero && (acc_r < vthr_r); // [R7]
    ev[qdec_pkg::ST_COMB]  = ev[qdec_pkg::ST_CMP0] &&
                             (rev_nxt == icmp_r); // [R11]
    ev[qdec_pkg::ST_INDEX] = idx_rise;
    ev[qdec_pkg::ST_VCAP]  = tmr_zero;
    ev[qdec_pkg::ST_PHERR] = both && !ctrl_r[qdec_pkg::CTRL_CLKDIR];
  end

  // APB register file
  always_comb
  begin
    wr_en = PSEL & PENABLE & PREADY & PWRITE;
    mapped = 1'b1;
    prdata_nxt = qdec_pkg::ZERO32;
    case (PADDR)
      qdec_pkg::OFF_CTRL: prdata_nxt = {29'h0000_0000, ctrl_r};
      qdec_pkg::OFF_POS:  prdata_nxt = pos_r;
      qdec_pkg::OFF_VEL:  prdata_nxt = vel_r;
      qdec_pkg::OFF_REV:  prdata_nxt = rev_r;
      qdec_pkg::OFF_VPER: prdata_nxt = vper_r;
      qdec_pkg::OFF_VTHR: prdata_nxt = vthr_r;
      qdec_pkg::OFF_CMP0: prdata_nxt = cmp_r[0];
      qdec_pkg::OFF_CMP1: prdata_nxt = cmp_r[1];
      qdec_pkg::OFF_CMP2: prdata_nxt = cmp_r[2];
      qdec_pkg::OFF_ICMP: prdata_nxt = icmp_r;
      qdec_pkg::OFF_FILT: prdata_nxt = {16'h0000, filt_r};
      qdec_pkg::OFF_STAT: prdata_nxt = {23'h00_0000, stat_r};
      qdec_pkg::OFF_IEN:  prdata_nxt = {23'h00_0000, ien_r};
      default:            mapped = 1'b0;
    endcase
    // Answer lands in the first access cycle
    pready_nxt  = PSEL & ~PENABLE;
    pslverr_nxt = PSEL & ~PENABLE & ~mapped;
    if (!(PSEL & ~PENABLE) || PWRITE)
      prdata_nxt = qdec_pkg::ZERO32;
    ctrl_nxt = ctrl_r;
    vper_nxt = vper_r;
    vthr_nxt = vthr_r;
    icmp_nxt = icmp_r;
    filt_nxt = filt_r;
    ien_nxt  = ien_r;
    w1c      = '0;
    for (int i = 0; i < 3; i++)
      cmp_nxt[i] = cmp_r[i];
    if (wr_en)
    begin
      case (PADDR)
        qdec_pkg::OFF_CTRL: ctrl_nxt = PWDATA[qdec_pkg::CTRL_W-1:0];
        qdec_pkg::OFF_VPER: vper_nxt = PWDATA;
        qdec_pkg::OFF_VTHR: vthr_nxt = PWDATA;
        qdec_pkg::OFF_CMP0: cmp_nxt[0] = PWDATA;
        qdec_pkg::OFF_CMP1: cmp_nxt[1] = PWDATA;
        qdec_pkg::OFF_CMP2: cmp_nxt[2] = PWDATA;
        qdec_pkg::OFF_ICMP: icmp_nxt = PWDATA;
        qdec_pkg::OFF_FILT: filt_nxt = PWDATA[qdec_pkg::FILT_W-1:0];
        qdec_pkg::OFF_STAT: w1c = PWDATA[qdec_pkg::ST_W-1:0];
        qdec_pkg::OFF_IEN:  ien_nxt = PWDATA[qdec_pkg::ST_W-1:0];
        default:            w1c = '0;
      endcase
    end
    // New event beats a clear in the same cycle [R14]
    stat_nxt = (stat_r & ~w1c) | ev;
    irq_nxt  = |(stat_nxt & ien_nxt); // [R14]
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET) // [R16]
    begin
      prev_r  <= '0;
      ctrl_r  <= qdec_pkg::CTRL_RST;
      pos_r   <= qdec_pkg::ZERO32;
      rev_r   <= qdec_pkg::ZERO32;
      vel_r   <= qdec_pkg::ZERO32;
      acc_r   <= qdec_pkg::ZERO32;
      tmr_r   <= qdec_pkg::VPER_RST;
      vper_r  <= qdec_pkg::VPER_RST;
      vthr_r  <= qdec_pkg::VTHR_RST;
      icmp_r  <= qdec_pkg::CMP_RST;
      filt_r  <= qdec_pkg::FILT_RST;
      stat_r  <= '0;
      ien_r   <= '0;
      DIR     <= 1'b0;
      IRQ     <= 1'b0;
      PRDATA  <= qdec_pkg::ZERO32;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      for (int i = 0; i < 3; i++)
        cmp_r[i] <= qdec_pkg::CMP_RST;
    end
    else
    begin
      prev_r  <= flt;
      ctrl_r  <= ctrl_nxt;
      pos_r   <= pos_nxt;
      rev_r   <= rev_nxt;
      vel_r   <= vel_nxt;
      acc_r   <= acc_nxt;
      tmr_r   <= tmr_nxt;
      vper_r  <= vper_nxt;
      vthr_r  <= vthr_nxt;
      icmp_r  <= icmp_nxt;
      filt_r  <= filt_nxt;
      stat_r  <= stat_nxt;
      ien_r   <= ien_nxt;
      DIR     <= dir_nxt;
      IRQ     <= irq_nxt;
      PRDATA  <= prdata_nxt;
      PREADY  <= pready_nxt;
      PSLVERR <= pslverr_nxt;
      for (int i = 0; i < 3; i++)
        cmp_r[i] <= cmp_nxt[i];
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  a_pos_step_up: assert property ( // [R2]
    step_up && !clr_pos |=> pos_r == $past(pos_r) + 32'h0000_0001)
    else $error("position did not count up");
  a_pos_step_dn: assert property ( // [R2]
    step_dn && !clr_pos |=> pos_r == $past(pos_r) - 32'h0000_0001)
    else $error("position did not count down");
  a_both_ignored: assert property ( // [R15]
    chg_a && chg_b && !ctrl_r[1] && !clr_pos |=> $stable(pos_r))
    else $error("double phase change was counted");
  a_x2_skips_b: assert property ( // [R3]
    !ctrl_r[0] && !ctrl_r[1] && !chg_a && chg_b && !clr_pos
      |=> $stable(pos_r))
    else $error("B edge counted in 2x mode");
  a_clkdir_step: assert property ( // [R13]
    ctrl_r[1] && flt.a && !prev_r.a && !flt.b && !clr_pos
      |=> pos_r == $past(pos_r) + 32'h0000_0001)
    else $error("clock-direction step missed");
  a_idx_clear: assert property ( // [R4]
    idx_rise && ctrl_r[2] |=> pos_r == 32'h0000_0000)
    else $error("index did not clear position");
  a_rev_moves: assert property ( // [R9]
    idx_rise |=> rev_r != $past(rev_r))
    else $error("revolution count did not move");
  a_vel_capture: assert property ( // [R6]
    tmr_zero |=> vel_r == $past(acc_r) && tmr_r == $past(vper_r))
    else $error("velocity capture wrong");
  a_vel_low_flag: assert property ( // [R7]
    tmr_zero && acc_r < vthr_r |=> stat_r[4] ##1 stat_r[4] || $past(w1c[4]))
    else $error("low velocity flag missing");
  a_cmp_flag: assert property ( // [R8]
    ev[1] |=> stat_r[1])
    else $error("compare 1 flag not set");
  a_comb_flag: assert property ( // [R11]
    ev[0] && rev_nxt == icmp_r |=> stat_r[5] && stat_r[0])
    else $error("combined flag not set");
  a_stat_sticky: assert property ( // [R14]
    stat_r[6] && !w1c[6] |=> stat_r[6])
    else $error("status flag dropped without clear");
  a_irq_gate: assert property ( // [R14]
    (stat_r & ien_r) == '0 |-> !IRQ)
    else $error("interrupt without enabled flag");
  a_irq_raise: assert property ( // [R14]
    (stat_r & ien_r) != '0 |-> IRQ)
    else $error("enabled flag without interrupt");
  a_dir_up: assert property ( // [R1]
    step_up |=> DIR)
    else $error("direction not up after up step");
  a_dir_dn: assert property ( // [R1]
    step_dn |=> !DIR)
    else $error("direction not down after down step");
  a_pos_idle: assert property ( // [R1]
    !step && !clr_pos |=> $stable(pos_r))
    else $error("position moved without a step");
  a_x4_counts_b: assert property ( // [R3]
    ctrl_r[qdec_pkg::CTRL_X4] && !ctrl_r[qdec_pkg::CTRL_CLKDIR] &&
      chg_b && !chg_a && !clr_pos |=> pos_r != $past(pos_r))
    else $error("B edge missed in 4x mode");
  a_clkdir_fall: assert property ( // [R13]
    ctrl_r[qdec_pkg::CTRL_CLKDIR] && !flt.a && prev_r.a && !clr_pos
      |=> $stable(pos_r))
    else $error("falling count clock was counted");
  a_pherr_flag: assert property ( // [R15]
    both && !ctrl_r[qdec_pkg::CTRL_CLKDIR] |=> stat_r[qdec_pkg::ST_PHERR])
    else $error("phase error flag not set");
  a_vcap_flag: assert property ( // [R6]
    tmr_zero |=> stat_r[qdec_pkg::ST_VCAP])
    else $error("capture flag not set");
  a_icmp_flag: assert property ( // [R10]
    idx_rise && rev_nxt == icmp_r |=> stat_r[qdec_pkg::ST_ICMP])
    else $error("index compare flag not set");
  a_tmr_reload: assert property ( // [R6]
    !tmr_zero && wr_en && PADDR == qdec_pkg::OFF_VPER
      |=> tmr_r == $past(PWDATA))
    else $error("period write did not restart timer");
endmodule
`default_nettype wire

//--- testbench/qdec_enc_model.sv
// Partner model: incremental encoder driving two phases and an index
`timescale 1ns/1ps
`default_nettype none
module qdec_enc_model #(
  parameter int HOLD = 10
) (
  // Clock that paces the edges
  input  wire logic               clk,
  // Encoder lines
  output var qdec_pkg::qdec_enc_t enc
);
  logic [1:0] ph = 2'h0;

  initial enc = '0;

  // Levels change just after an edge and hold for n more cycles
  task automatic drive(input logic a, input logic b, input logic i,
                       input int n);
    @(posedge clk);
    enc <= {i, b, a};
    repeat (n) @(posedge clk);
  endtask

  // Gray sequence 00-10-11-01: A leads B when moving up
  task automatic step(input logic up);
    ph = up ? ph + 2'h1 : ph - 2'h1;
    drive(ph[0] ^ ph[1], ph[1], enc.idx, HOLD);
  endtask

  task automatic pulse_index;
    drive(enc.a, enc.b, 1'b1, HOLD);
    drive(enc.a, enc.b, 1'b0, HOLD);
  endtask

  // Illegal jump: both phases flip in one go
  task automatic swap_both;
    drive(~enc.a, ~enc.b, enc.idx, HOLD);
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Testbench: registers, counting, compares and interrupt of the decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic        err;
  } qdec_row_t;

  logic                clk        = 1'b0;
  logic                rst        = 1'b1;
  logic                psel       = 1'b0;
  logic                penable    = 1'b0;
  logic                pwrite     = 1'b0;
  logic [7:0]          paddr      = 8'h00;
  logic [31:0]         pwdata     = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                irq;
  logic                dir;
  qdec_pkg::qdec_enc_t enc;
  int                  num_errors = 0;
  int                  compares   = 0;
  logic [31:0]         pos;
  logic [31:0]         rd;
  logic                er;
  qdec_row_t           rows [19];

  always #5 clk = ~clk;

  qdec_top i_qdec_top (
    .CORE_CLK (clk),
    .RESET    (rst),
    .PSEL     (psel),
    .PENABLE  (penable),
    .PWRITE   (pwrite),
    .PADDR    (paddr),
    .PWDATA   (pwdata),
    .PRDATA   (prdata),
    .PREADY   (pready),
    .PSLVERR  (pslverr),
    .ENC_A    (enc.a),
    .ENC_B    (enc.b),
    .ENC_IDX  (enc.idx),
    .IRQ      (irq),
    .DIR      (dir)
  );

  qdec_enc_model i_qdec_enc_model (
    .clk (clk),
    .enc (enc)
  );

  task print_verdict;
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Ready and data are taken at the rising edge, before its updates land
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 20)
    begin
      num_errors++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input string name, input logic [7:0] a,
             input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd & m, exp);
  endtask

  task steps(input logic up, input int n);
    repeat (n) i_qdec_enc_model.step(up);
    pos = up ? pos + 32'(n) : pos - 32'(n);
  endtask

  task settle;
    repeat (3) @(negedge clk);
  endtask

  task poll_vcap;
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[qdec_pkg::ST_VCAP] !== 1'b1 && n < 400)
    begin
      apb(1'b0, qdec_pkg::OFF_STAT, 32'h0);
      n++;
    end
    if (n == 400)
    begin
      num_errors++;
      print_verdict();
    end
  endtask

  initial
  begin
    rows = '{'{1'b0, qdec_pkg::OFF_CTRL, 32'h1, 1'b0},
             '{1'b0, qdec_pkg::OFF_POS, 32'h0, 1'b0},
             '{1'b0, qdec_pkg::OFF_VEL, 32'h0, 1'b0},
             '{1'b0, qdec_pkg::OFF_REV, 32'h0, 1'b0},
             '{1'b0, qdec_pkg::OFF_VPER, qdec_pkg::VPER_RST, 1'b0},
             '{1'b0, qdec_pkg::OFF_VTHR, 32'h0, 1'b0},
             '{1'b0, qdec_pkg::OFF_CMP0, qdec_pkg::CMP_RST, 1'b0},
             '{1'b0, qdec_pkg::OFF_CMP1, qdec_pkg::CMP_RST, 1'b0},
             '{1'b0, qdec_pkg::OFF_CMP2, qdec_pkg::CMP_RST, 1'b0},
             '{1'b0, qdec_pkg::OFF_ICMP, qdec_pkg::CMP_RST, 1'b0},
             '{1'b0, qdec_pkg::OFF_FILT, 32'h3, 1'b0},
             '{1'b0, qdec_pkg::OFF_STAT, 32'h0, 1'b0},
             '{1'b0, qdec_pkg::OFF_IEN, 32'h0, 1'b0},
             '{1'b0, 8'h34, 32'h0, 1'b1},
             '{1'b1, qdec_pkg::OFF_POS, 32'h55, 1'b0},
             '{1'b0, qdec_pkg::OFF_POS, 32'h0, 1'b0},
             '{1'b1, qdec_pkg::OFF_IEN, 32'h1FF, 1'b0},
             '{1'b0, qdec_pkg::OFF_IEN, 32'h1FF, 1'b0},
             '{1'b1, qdec_pkg::OFF_IEN, 32'h0, 1'b0}};
    pos = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[k])
    begin
      apb(rows[k].wr, rows[k].addr, rows[k].data);
      if (!rows[k].wr)
        check("register", rd, rows[k].data);
      check("slave error", {31'h0, er}, {31'h0, rows[k].err});
    end
    check("irq", {31'h0, irq}, 32'h0);
    steps(1'b1, 4);
    rdchk("pos up", qdec_pkg::OFF_POS, '1, pos);
    check("dir up", {31'h0, dir}, 32'h1);
    steps(1'b0, 5);
    rdchk("pos wrap", qdec_pkg::OFF_POS, '1, pos);
    check("dir down", {31'h0, dir}, 32'h0);
    steps(1'b1, 1);
    wr(qdec_pkg::OFF_CTRL, 32'h0);
    repeat (4) i_qdec_enc_model.step(1'b1);
    pos = pos + 32'h2;
    rdchk("pos 2x", qdec_pkg::OFF_POS, '1, pos);
    wr(qdec_pkg::OFF_CTRL, 32'h1);
    wr(qdec_pkg::OFF_STAT, '1);
    i_qdec_enc_model.swap_both();
    rdchk("phase err", qdec_pkg::OFF_STAT, 32'h100, 32'h100);
    i_qdec_enc_model.swap_both();
    rdchk("pos jump", qdec_pkg::OFF_POS, '1, pos);
    for (int k = 0; k < 3; k++)
    begin
      wr(qdec_pkg::OFF_CMP0 + 8'(4 * k), pos + 32'h1);
      wr(qdec_pkg::OFF_STAT, '1);
      steps(1'b1, 1);
      rdchk("cmp flag", qdec_pkg::OFF_STAT, 32'h7, 32'h1 << k);
    end
    wr(qdec_pkg::OFF_IEN, 32'h3);
    settle();
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(qdec_pkg::OFF_IEN, 32'h4);
    settle();
    check("irq on", {31'h0, irq}, 32'h1);
    wr(qdec_pkg::OFF_STAT, 32'h4);
    settle();
    check("irq cleared", {31'h0, irq}, 32'h0);
    wr(qdec_pkg::OFF_ICMP, 32'h1);
    wr(qdec_pkg::OFF_CMP0, 32'h1);
    wr(qdec_pkg::OFF_CTRL, 32'h5);
    wr(qdec_pkg::OFF_STAT, '1);
    i_qdec_enc_model.pulse_index();
    pos = 32'h0;
    rdchk("rev", qdec_pkg::OFF_REV, '1, 32'h1);
    rdchk("pos index", qdec_pkg::OFF_POS, '1, pos);
    rdchk("index flags", qdec_pkg::OFF_STAT, 32'h69, 32'h48);
    steps(1'b1, 1);
    rdchk("combined", qdec_pkg::OFF_STAT, 32'h69, 32'h69);
    wr(qdec_pkg::OFF_CTRL, 32'h1);
    // Short period so a capture lands within the run
    wr(qdec_pkg::OFF_VTHR, 32'h64);
    wr(qdec_pkg::OFF_VPER, 32'hC8);
    poll_vcap();
    wr(qdec_pkg::OFF_STAT, '1);
    steps(1'b1, 3);
    poll_vcap();
    check("vel low", rd & 32'h10, 32'h10);
    rdchk("vel", qdec_pkg::OFF_VEL, '1, 32'h3);
    wr(qdec_pkg::OFF_CTRL, 32'h2);
    wr(qdec_pkg::OFF_FILT, 32'h14);
    i_qdec_enc_model.drive(1'b0, 1'b1, 1'b0, 30);
    i_qdec_enc_model.drive(1'b1, 1'b1, 1'b0, 5);
    i_qdec_enc_model.drive(1'b0, 1'b1, 1'b0, 30);
    rdchk("glitch", qdec_pkg::OFF_POS, '1, pos);
    i_qdec_enc_model.drive(1'b1, 1'b1, 1'b0, 30);
    i_qdec_enc_model.drive(1'b0, 1'b1, 1'b0, 30);
    pos = pos - 32'h1;
    rdchk("clk dn", qdec_pkg::OFF_POS, '1, pos);
    check("dir dn", {31'h0, dir}, 32'h0);
    i_qdec_enc_model.drive(1'b0, 1'b0, 1'b0, 30);
    i_qdec_enc_model.drive(1'b1, 1'b0, 1'b0, 30);
    pos = pos + 32'h1;
    rdchk("clk up", qdec_pkg::OFF_POS, '1, pos);
    check("dir up", {31'h0, dir}, 32'h1);
    wr(qdec_pkg::OFF_IEN, 32'h1FF);
    settle();
    check("irq pend", {31'h0, irq}, 32'h1);
    // Idle lines so no filtered edge follows the reset
    i_qdec_enc_model.drive(1'b0, 1'b0, 1'b0, 30);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check("irq rst", {31'h0, irq}, 32'h0);
    rdchk("pos rst", qdec_pkg::OFF_POS, '1, 32'h0);
    rdchk("rev rst", qdec_pkg::OFF_REV, '1, 32'h0);
    rdchk("ien rst", qdec_pkg::OFF_IEN, '1, 32'h0);
    rdchk("stat rst", qdec_pkg::OFF_STAT, '1, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
